// ===== core/modbus_server_exception_map_params.svh
// constants of the query checker: codes, references, masks, reset values
// assumes the includer works on 8-bit function codes and 16-bit words
`ifndef MODBUS_SERVER_EXCEPTION_MAP_PARAMS_SVH
`define MODBUS_SERVER_EXCEPTION_MAP_PARAMS_SVH

// exception codes returned to the client
`define EXC_ILLEGAL_FUNCTION   8'h01
`define EXC_ILLEGAL_ADDRESS    8'h02
`define EXC_ILLEGAL_VALUE      8'h03
`define EXC_DEVICE_FAILURE     8'h04
`define EXC_DEVICE_BUSY        8'h06

// function codes this block answers
`define FC_READ_COILS          8'h01
`define FC_READ_DISCRETE       8'h02
`define FC_READ_HOLDING        8'h03
`define FC_WRITE_COIL          8'h05
`define FC_WRITE_HOLDING       8'h06
`define FC_DIAGNOSTICS         8'h08
`define DIAG_CLEAR_OVERRUN     16'h0014

// coil write values
`define COIL_ON_VALUE          16'hff00
`define COIL_OFF_VALUE         16'h0000

// holding references of the error registers
`define REF_ERROR_CLEAR        16'h0059
`define REF_FAILED_FUNC        16'h005a
`define REF_FAILURE_REASON     16'h005b
`define REF_FAILED_REG         16'h005c
`define REF_LAST_WRITE         16'h005d
`define REF_LAST_READ          16'h005e

// failure reason values
`define REASON_NONE            8'h00
`define REASON_LIMIT           8'h02
`define REASON_INDEX           8'h03
`define REASON_DATA_TYPE       8'h05
`define REASON_GENERAL         8'h65

// populated references per profile, bit n set = reference n in use
`define COIL_MASK_DRIVES       32'h0000ffff
`define COIL_MASK_ALT          32'h03c33bf3
`define DISC_MASK_DRIVES       32'h00007fff
`define DISC_MASK_ALT          32'h07c1f39b

`define REG_RESET_VALUE        16'h0000
`define CTRL_RESET_VALUE       32'h0000_0000

`endif

// ===== core/modbus_server_exception_map_pkg.sv
// types shared by the query checker
// assumes the params header is included by every user of the package
package modbus_server_exception_map_pkg;

    // profile that maps coils and discrete inputs
    typedef enum logic
    {
        PROFILE_DRIVES = 1'b0,
        PROFILE_ALT    = 1'b1
    } profile_t;

    // whole state of the checker
    typedef struct packed
    {
        logic [31:0] coil_word;
        logic [15:0] failed_function_code;
        logic [15:0] failure_reason_code;
        logic [15:0] failed_register_addr;
        logic [15:0] last_good_write_addr;
        logic [15:0] last_good_read_addr;
        logic        resp_valid;
        logic        resp_exception;
        logic [7:0]  resp_func;
        logic [7:0]  resp_exc_code;
        logic [15:0] resp_data;
        logic        overrun_clear;
    } state_t;

endpackage

// ===== core/modbus_server_exception_map.sv
// query checker of the embedded fieldbus server: exception answers,
// coil and discrete-input mapping, and the error holding registers
// assumes framing logic on sys_clk hands over one decoded query at a time
//
// Behaviour
// - a function code not handled here answers exception 01h
// - an address outside the populated set answers exception 02h
// - an unacceptable value or quantity answers exception 03h
// - an internal failure answers 04h and records its details
// - while the drive is busy every query answers exception 06h
// - coils are single bits the client reads and writes
// - coils map control bits: 0..15 drives, up to 25 alternate
// - coil and input references equal the wire address, no offset
// - discrete inputs are single bits, read only
// - inputs map status bits: 0..14 drives, up to 26 alternate
// - error registers describe the last failed, last written and last read queries
// - a successful query clears the failure reason to no error
// - writing 1 at reference 89 clears error registers; 0 does nothing
// - the function code of each failed query lands at reference 90
// - reference 91 loads the drive's reason on exception 04h; other exceptions leave it
// - reference 92 holds the last register that failed
// - reference 93 holds the last register written without error
// - reference 94 holds the last register read without error
// - diagnostics subcode 14h clears the overrun counter and flag
`timescale 1ns/1ns
`include "modbus_server_exception_map_params.svh"

module modbus_server_exception_map
(
    input  wire logic                                  sys_clk,
    input  wire logic                                  nrst,
    input  wire modbus_server_exception_map_pkg::profile_t profile_sel,
    input  wire logic                                  query_valid,
    input  wire logic [7:0]                            query_func,
    input  wire logic [15:0]                           query_addr,
    input  wire logic [15:0]                           query_value,
    input  wire logic                                  drive_busy,
    input  wire logic                                  exec_fail,
    input  wire logic [7:0]                            exec_fail_reason,
    input  wire logic [31:0]                           status_word,
    output logic                                       resp_valid,
    output logic                                       resp_exception,
    output logic [7:0]                                 resp_func,
    output logic [7:0]                                 resp_exc_code,
    output logic [15:0]                                resp_data,
    output logic [31:0]                                coil_word,
    output logic                                       ramp_stop_release,
    output logic                                       coast_stop_release,
    output logic                                       quick_stop_release,
    output logic                                       overrun_clear
);
    import modbus_server_exception_map_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state and its next value
    state_t      st;
    state_t      next_st;

    // decode helpers, filled by the combinational processes and assigns below
    logic [31:0] coil_mask;
    logic [31:0] disc_mask;
    logic        bit_in_range;
    logic [4:0]  bit_index;
    logic        failed;
    logic        is_write;
    logic [7:0]  exc;
    logic [15:0] read_data;
    logic [15:0] hold_value;
    logic        hold_known;
    logic        hold_writable;

    ////////////////////////////////////////////////////////////////////////
    // profile masks: one setting steers both bit spaces together
    always_comb
    begin
        if (profile_sel == PROFILE_ALT)
        begin
            coil_mask = `COIL_MASK_ALT;
            disc_mask = `DISC_MASK_ALT;
        end
        else
        begin
            coil_mask = `COIL_MASK_DRIVES;
            disc_mask = `DISC_MASK_DRIVES;
        end
    end

    // references are used as bit numbers directly, no offset removed
    assign bit_in_range = (query_addr[15:5] == 11'h000);
    assign bit_index    = query_addr[4:0];

    ////////////////////////////////////////////////////////////////////////
    // holding register read port; the clear trigger always reads zero
    // since it only acts at the moment of the write
    always_comb
    begin
        hold_known    = 1'b1;
        hold_writable = 1'b0;
        hold_value    = `REG_RESET_VALUE;
        case (query_addr)
            `REF_ERROR_CLEAR:
            begin
                hold_writable = 1'b1;
                hold_value    = `REG_RESET_VALUE;
            end
            `REF_FAILED_FUNC:    hold_value = st.failed_function_code;
            `REF_FAILURE_REASON: hold_value = st.failure_reason_code;
            `REF_FAILED_REG:     hold_value = st.failed_register_addr;
            `REF_LAST_WRITE:     hold_value = st.last_good_write_addr;
            `REF_LAST_READ:      hold_value = st.last_good_read_addr;
            default:             hold_known = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // query check: busy first, then function, address, value, and only
    // then the drive's own failure report, so 04h means the action ran
    always_comb
    begin
        exc       = 8'h00;
        is_write  = 1'b0;
        read_data = 16'h0000;
        case (query_func)
            `FC_READ_COILS:
            begin
                if (!bit_in_range || !coil_mask[bit_index])
                    exc = `EXC_ILLEGAL_ADDRESS;
                else if (query_value != 16'h0001)
                    exc = `EXC_ILLEGAL_VALUE;
                read_data = {15'h0000, st.coil_word[bit_index]};
            end
            `FC_WRITE_COIL:
            begin
                is_write = 1'b1;
                if (!bit_in_range || !coil_mask[bit_index])
                    exc = `EXC_ILLEGAL_ADDRESS;
                else if (query_value != `COIL_ON_VALUE &&
                         query_value != `COIL_OFF_VALUE)
                    exc = `EXC_ILLEGAL_VALUE;
                read_data = query_value;                  // echo
            end
            // the input space has only this read path: no write code
            // reaches it, so a write there falls to illegal function
            `FC_READ_DISCRETE:
            begin
                if (!bit_in_range || !disc_mask[bit_index])
                    exc = `EXC_ILLEGAL_ADDRESS;
                else if (query_value != 16'h0001)
                    exc = `EXC_ILLEGAL_VALUE;
                read_data = {15'h0000, status_word[bit_index]};
            end
            `FC_READ_HOLDING:
            begin
                if (!hold_known)
                    exc = `EXC_ILLEGAL_ADDRESS;
                else if (query_value != 16'h0001)
                    exc = `EXC_ILLEGAL_VALUE;
                read_data = hold_value;
            end
            `FC_WRITE_HOLDING:
            begin
                is_write = 1'b1;
                if (!hold_known || !hold_writable)
                    exc = `EXC_ILLEGAL_ADDRESS;
                else if (query_value > 16'h0001)
                    exc = `EXC_ILLEGAL_VALUE;
                read_data = query_value;                  // echo
            end
            `FC_DIAGNOSTICS:
            begin
                // only the overrun clear subcode is served here
                if (query_addr != `DIAG_CLEAR_OVERRUN)
                    exc = `EXC_ILLEGAL_VALUE;
                read_data = query_value;                  // echo
            end
            default:
                exc = `EXC_ILLEGAL_FUNCTION;
        endcase
        // failure of the action itself only counts for a valid query
        if (exc == 8'h00 && exec_fail)
            exc = `EXC_DEVICE_FAILURE;
        // a busy drive refuses everything, whatever the query holds
        if (drive_busy)
            exc = `EXC_DEVICE_BUSY;
    end

    assign failed = (exc != 8'h00);

    ////////////////////////////////////////////////////////////////////////
    // next state: coil writes, error register upkeep, response capture
    always_comb
    begin
        next_st               = st;
        next_st.resp_valid    = 1'b0;
        next_st.overrun_clear = 1'b0;
        if (query_valid)
        begin
            next_st.resp_valid     = 1'b1;
            next_st.resp_func      = query_func;
            next_st.resp_exception = failed;
            next_st.resp_exc_code  = exc;
            next_st.resp_data      = failed ? 16'h0000 : read_data;
            if (failed)
            begin
                // the error registers follow the query just handled
                next_st.failed_function_code =
                    {8'h00, query_func};
                next_st.failed_register_addr = query_addr;
                if (exc == `EXC_DEVICE_FAILURE)
                    next_st.failure_reason_code =
                        {8'h00, exec_fail_reason};
            end
            else
            begin
                next_st.failure_reason_code =
                    {8'h00, `REASON_NONE};
                if (query_func == `FC_WRITE_COIL)
                    next_st.coil_word[bit_index] =
                        (query_value == `COIL_ON_VALUE);
                if (query_func == `FC_DIAGNOSTICS)
                    next_st.overrun_clear = 1'b1;
                if (is_write && query_func != `FC_DIAGNOSTICS)
                    next_st.last_good_write_addr = query_addr;
                if (!is_write && query_func != `FC_DIAGNOSTICS)
                    next_st.last_good_read_addr = query_addr;
                // clear trigger: 1 wipes the error registers, 0 is a no-op;
                // the clear beats the write-address update of this query
                if (query_func == `FC_WRITE_HOLDING &&
                    query_value == 16'h0001)
                begin
                    next_st.failed_function_code = `REG_RESET_VALUE;
                    next_st.failure_reason_code  = `REG_RESET_VALUE;
                    next_st.failed_register_addr = `REG_RESET_VALUE;
                    next_st.last_good_write_addr = `REG_RESET_VALUE;
                    next_st.last_good_read_addr  = `REG_RESET_VALUE;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register, constants only under reset
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st                      <= '0;
            st.coil_word            <= `CTRL_RESET_VALUE;
            st.failed_function_code <= `REG_RESET_VALUE;
            st.failure_reason_code  <= `REG_RESET_VALUE;
            st.failed_register_addr <= `REG_RESET_VALUE;
            st.last_good_write_addr <= `REG_RESET_VALUE;
            st.last_good_read_addr  <= `REG_RESET_VALUE;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register
    assign resp_valid     = st.resp_valid;
    assign resp_exception = st.resp_exception;
    assign resp_func      = st.resp_func;
    assign resp_exc_code  = st.resp_exc_code;
    assign resp_data      = st.resp_data;
    assign coil_word      = st.coil_word;
    assign overrun_clear  = st.overrun_clear;

    // stop releases are the low coils; under the alternate profile these
    // coils carry other commands, so the drive must qualify by profile
    assign ramp_stop_release  = st.coil_word[0];
    assign coast_stop_release = st.coil_word[1];
    assign quick_stop_release = st.coil_word[2];

endmodule

// ===== tb/modbus_server_exception_map_asserts.sv
// checker of answer timing and exception codes of the query checker
// assumes a bind to the top module; one clock domain, nrst async low
`timescale 1ns/1ns
`include "modbus_server_exception_map_params.svh"
module modbus_server_exception_map_asserts
(
    input wire logic                                      sys_clk,
    input wire logic                                      nrst,
    input wire modbus_server_exception_map_pkg::profile_t profile_sel,
    input wire logic                                      query_valid,
    input wire logic [7:0]                                query_func,
    input wire logic [15:0]                               query_addr,
    input wire logic [15:0]                               query_value,
    input wire logic                                      drive_busy,
    input wire logic                                      exec_fail,
    input wire logic [31:0]                               status_word,
    input wire logic                                      resp_valid,
    input wire logic                                      resp_exception,
    input wire logic [7:0]                                resp_exc_code,
    input wire logic [15:0]                               resp_data,
    input wire logic [31:0]                               coil_word,
    input wire logic                                      ramp_stop_release,
    input wire logic                                      overrun_clear
);
import modbus_server_exception_map_pkg::*;
default clocking @(posedge sys_clk); endclocking
default disable iff (!nrst);
// a query that is not refused as busy
wire logic free = query_valid && !drive_busy;
wire logic drv  = profile_sel == PROFILE_DRIVES;
logic      disc_bit;
// input bit seen with the query, kept for the answer a cycle later
always_ff @(posedge sys_clk)
    disc_bit <= status_word[query_addr[4:0]];
property p_lat; query_valid |=> resp_valid; endproperty
a_lat: assert property (p_lat) else $error("no answer");
property p_busy; query_valid && drive_busy |=> resp_exception
    && resp_exc_code == `EXC_DEVICE_BUSY; endproperty
a_busy: assert property (p_busy) else $error("busy");
property p_func; free && !(query_func inside {8'h01, 8'h02, 8'h03,
    8'h05, 8'h06, 8'h08}) |=> resp_exc_code == `EXC_ILLEGAL_FUNCTION;
endproperty
a_func: assert property (p_func) else $error("func");
property p_coil; free && drv && query_func == `FC_READ_COILS
    && query_addr > 16'h000f |=> resp_exc_code == `EXC_ILLEGAL_ADDRESS;
endproperty
a_coil: assert property (p_coil) else $error("coil addr");
property p_fail; free && exec_fail && drv && query_func == `FC_READ_COILS
    && query_addr < 16'h0010 && query_value == 16'h0001
    |=> resp_exc_code == `EXC_DEVICE_FAILURE; endproperty
a_fail: assert property (p_fail) else $error("fail");
property p_disc; free && !exec_fail && drv
    && query_func == `FC_READ_DISCRETE && query_addr < 16'h000f
    && query_value == 16'h0001 |=> !resp_exception
    && resp_data[0] == disc_bit; endproperty
a_disc: assert property (p_disc) else $error("input bit");
property p_exc; resp_valid && resp_exception
    |-> resp_exc_code != 8'h00 && resp_data == 16'h0000; endproperty
a_exc: assert property (p_exc) else $error("exception data");
property p_ovr; free && !exec_fail && query_func == `FC_DIAGNOSTICS
    && query_addr == `DIAG_CLEAR_OVERRUN |=> overrun_clear; endproperty
a_ovr: assert property (p_ovr) else $error("overrun");
property p_tie; ramp_stop_release == coil_word[0]; endproperty
a_tie: assert property (p_tie) else $error("coil 0");
endmodule

// ===== tb/modbus_client_model.sv
// client model: puts one query a cycle on the query port
// assumes one bench process calls send and idle
`timescale 1ns/1ns
module modbus_client_model
(
    input  wire logic  sys_clk,
    output logic       query_valid,
    output logic [7:0] query_func,
    output logic [15:0] query_addr,
    output logic [15:0] query_value
);
initial
begin
    query_valid = 1'b0;
    query_func  = 8'h00;
    query_addr  = 16'h0000;
    query_value = 16'h0000;
end
// one call a cycle gives back to back queries
task automatic send(input logic [7:0] f, input logic [15:0] a,
    input logic [15:0] v);
begin
    @(posedge sys_clk);
    #1;
    query_valid = 1'b1;
    query_func  = f;
    query_addr  = a;
    query_value = v; // a clear writes 1 only when meant
end
endtask
// released fields flip so a stale query never looks valid
task automatic idle;
begin
    @(posedge sys_clk);
    #1;
    query_valid = 1'b0;
    query_func  = ~query_func;
    query_addr  = ~query_addr;
    query_value = ~query_value;
end
endtask
endmodule

// ===== tb/modbus_server_exception_map_test.sv
// bench: client model drives queries, a monitor compares answers
// assumes design, checker and client model are compiled first
`timescale 1ns/1ns
`include "modbus_server_exception_map_params.svh"
module modbus_server_exception_map_test;
import modbus_server_exception_map_pkg::*;
localparam logic [15:0] z16 = 16'h0000;
localparam logic [15:0] one = 16'h0001;
// {profile, input space, legal, address}
localparam logic [7:0] tab [10] = '{8'h2f, 8'h10, 8'h82, 8'ha0, 8'hb9,
    8'h9a, 8'h6e, 8'h4f, 8'hfa, 8'hdb};
localparam logic [7:0] rs [5] = '{`REASON_NONE, `REASON_LIMIT,
    `REASON_INDEX, `REASON_DATA_TYPE, `REASON_GENERAL};
logic sys_clk = 1'b0;
logic nrst = 1'b0;
profile_t profile_sel = PROFILE_DRIVES;
profile_t np = PROFILE_DRIVES;
logic drive_busy = 1'b0;
logic exec_fail = 1'b0;
logic nb = 1'b0;
logic nf = 1'b0;
logic [7:0] exec_fail_reason = 8'h00;
logic [7:0] nr = 8'h00;
logic [31:0] status_word = 32'h0000_0000;
logic query_valid, resp_valid, resp_exception, overrun_clear;
logic [7:0] query_func, resp_func, resp_exc_code, t;
logic [15:0] query_addr, query_value, resp_data, n;
logic [31:0] coil_word, got;
logic ramp_stop_release, coast_stop_release, quick_stop_release;
logic [31:0] expq [$];
int n_mismatch = 0;
int comparisons = 0;
int seed = 45;
always #5 sys_clk = ~sys_clk;
modbus_client_model client (.sys_clk(sys_clk), .query_valid(query_valid),
    .query_func(query_func), .query_addr(query_addr),
    .query_value(query_value));
modbus_server_exception_map i_dut (.sys_clk(sys_clk), .nrst(nrst),
    .profile_sel(profile_sel), .query_valid(query_valid),
    .query_func(query_func), .query_addr(query_addr),
    .query_value(query_value), .drive_busy(drive_busy),
    .exec_fail(exec_fail), .exec_fail_reason(exec_fail_reason),
    .status_word(status_word), .resp_valid(resp_valid),
    .resp_exception(resp_exception), .resp_func(resp_func),
    .resp_exc_code(resp_exc_code), .resp_data(resp_data),
    .coil_word(coil_word), .ramp_stop_release(ramp_stop_release),
    .coast_stop_release(coast_stop_release),
    .quick_stop_release(quick_stop_release),
    .overrun_clear(overrun_clear));
task automatic results;
begin
    if (n_mismatch == 0 && comparisons > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
end
endtask
task automatic chk(input logic ok);
begin
    comparisons++;
    if (ok !== 1'b1)
    begin
        n_mismatch++;
        $display("CHECK FAILED %0t wrong port value", $time);
    end
end
endtask
// side inputs follow the query so they qualify that query only
task automatic q(input logic [7:0] f, input logic [15:0] a,
    input logic [15:0] v, input logic [7:0] e, input logic [15:0] d);
begin
    client.send(f, a, v);
    drive_busy = nb;
    exec_fail = nf;
    exec_fail_reason = nr;
    profile_sel = np;
    expq.push_back({f, e, d});
end
endtask
// answers are settled by the falling edge
always @(negedge sys_clk)
    if (resp_valid === 1'b1)
    begin
        got = (expq.size() > 0) ? expq.pop_front() : 32'hffff_ffff;
        comparisons++;
        if ({resp_func, resp_exc_code, resp_data} !== got
            || resp_exception !== (got[23:16] != 8'h00))
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t wrong answer", $time);
        end
    end
initial
begin
    #100000;
    n_mismatch++;
    results();
end
initial
begin
    repeat (8) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    status_word = $random(seed);
    n = 16'($random(seed)) & 16'h000f;
    for (int i = 0; i < 5; i++)
        q(`FC_READ_HOLDING, `REF_FAILED_FUNC + 16'(i), one, 8'h00,
          (i == 4) ? `REF_LAST_WRITE : z16);
    q(`FC_WRITE_COIL, n, `COIL_ON_VALUE, 8'h00, `COIL_ON_VALUE);
    q(`FC_READ_COILS, n, one, 8'h00, one);
    q(`FC_WRITE_COIL, n, 16'h1234, `EXC_ILLEGAL_VALUE, z16);
    q(`FC_READ_HOLDING, `REF_FAILED_FUNC, one, 8'h00, 16'h0005);
    q(`FC_READ_HOLDING, `REF_FAILED_REG, one, 8'h00, n);
    q(`FC_READ_HOLDING, `REF_LAST_WRITE, one, 8'h00, n);
    for (int i = 0; i < 10; i++)
    begin
        t = tab[i];
        np = profile_t'(t[7]);
        q(t[6] ? `FC_READ_DISCRETE : `FC_READ_COILS, {11'h000, t[4:0]}, one,
          t[5] ? 8'h00 : `EXC_ILLEGAL_ADDRESS, {15'h0000, t[5]
          & (t[6] ? status_word[t[4:0]] : t[4:0] == n[4:0])});
    end
    np = PROFILE_DRIVES;
    q(`FC_READ_COILS, one, 16'h0002, `EXC_ILLEGAL_VALUE, z16);
    q(8'h0f, z16, one, `EXC_ILLEGAL_FUNCTION, z16);
    q(`FC_WRITE_HOLDING, `REF_FAILED_FUNC, one, 8'h02, z16);
    q(`FC_WRITE_HOLDING, `REF_ERROR_CLEAR, 16'h0002, 8'h03, z16);
    q(`FC_READ_HOLDING, 16'h0060, one, `EXC_ILLEGAL_ADDRESS, z16);
    q(`FC_DIAGNOSTICS, 16'h0013, z16, `EXC_ILLEGAL_VALUE, z16);
    q(`FC_DIAGNOSTICS, `DIAG_CLEAR_OVERRUN, 16'h00a5, 8'h00,
      16'h00a5);
    nb = 1'b1;
    q(`FC_READ_COILS, z16, one, `EXC_DEVICE_BUSY, z16);
    q(8'h2b, z16, one, `EXC_DEVICE_BUSY, z16);
    nb = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
        nf = 1'b1;
        nr = rs[i];
        q(`FC_READ_COILS, one, one, `EXC_DEVICE_FAILURE, z16);
        nf = 1'b0;
        q(`FC_READ_HOLDING, `REF_FAILURE_REASON, one, 8'h00,
          {8'h00, rs[i]});
    end
    q(`FC_READ_HOLDING, `REF_FAILURE_REASON, one, 8'h00, z16);
    q(`FC_WRITE_HOLDING, `REF_ERROR_CLEAR, z16, 8'h00, z16);
    q(`FC_READ_HOLDING, `REF_FAILED_FUNC, one, 8'h00, one);
    q(`FC_WRITE_HOLDING, `REF_ERROR_CLEAR, one, 8'h00, one);
    q(`FC_READ_HOLDING, `REF_FAILED_FUNC, one, 8'h00, z16);
    q(`FC_READ_HOLDING, `REF_LAST_WRITE, one, 8'h00, z16);
    client.idle();
    repeat (2) @(posedge sys_clk);
    #1;
    chk(coil_word[n[4:0]] === 1'b1 && expq.size() == 0);
    // the stop releases are the three lowest coils
    chk({quick_stop_release, coast_stop_release, ramp_stop_release}
        === coil_word[2:0]);
    // second reset in mid run wipes the coils
    nrst = 1'b0;
    #20;
    chk(coil_word === 32'h0000_0000);
    nrst = 1'b1;
    q(`FC_READ_COILS, n, one, 8'h00, z16);
    client.idle();
    repeat (2) @(posedge sys_clk);
    results();
end
endmodule
bind modbus_server_exception_map modbus_server_exception_map_asserts i_chk (
    .sys_clk(sys_clk), .nrst(nrst), .profile_sel(profile_sel),
    .query_valid(query_valid), .query_func(query_func),
    .query_addr(query_addr), .query_value(query_value),
    .drive_busy(drive_busy), .exec_fail(exec_fail),
    .status_word(status_word), .resp_valid(resp_valid),
    .resp_exception(resp_exception), .resp_exc_code(resp_exc_code),
    .resp_data(resp_data), .coil_word(coil_word),
    .ramp_stop_release(ramp_stop_release), .overrun_clear(overrun_clear));
